// *** src/rha_pkg.sv ***
// Package with constants, states and carriers of the refresh and hold arbiter.
package rha_pkg;

  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned TIMER_SRC_HZ    = 1_190_000;
  // Divider for the timer source, rounded down to whole system clocks.
  localparam int unsigned TIMER_DIV       = CLK_HZ / TIMER_SRC_HZ;
  localparam int unsigned TDIV_W          = 4;
  localparam logic [TDIV_W-1:0] TDIV_LAST = TDIV_W'(TIMER_DIV - 1);

  localparam int unsigned REF_EDGES       = 4;
  localparam int unsigned REF_CNT_W       = 3;
  localparam logic [REF_CNT_W-1:0] REF_LAST = REF_CNT_W'(REF_EDGES - 1);
  localparam logic [REF_CNT_W-1:0] REF_CNT_RST = 3'h0;

  localparam int unsigned ADDR_W          = 8;
  localparam logic [ADDR_W-1:0] ADDR_RST  = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 8'h01;

  localparam int unsigned PORT_W          = 8;
  localparam int unsigned PORT_REF_BIT    = 4;
  localparam int unsigned PORT_SPK_BIT    = 5;

  localparam int unsigned SYNC_W          = 8;
  localparam int unsigned PIN_DMA_CLOCK   = 0;
  localparam int unsigned PIN_DMA_HOLD    = 1;
  localparam int unsigned PIN_TIMER1      = 2;
  localparam int unsigned PIN_HOLD_ACK    = 3;
  localparam int unsigned PIN_CH_READY    = 4;
  localparam int unsigned PIN_BUS_CLOCK   = 5;
  localparam int unsigned PIN_TIMER0      = 6;
  localparam int unsigned PIN_TIMER2      = 7;

  typedef enum logic [5:0] {
    ST_IDLE     = 6'h01,
    ST_DMA_WAIT = 6'h02,
    ST_DMA      = 6'h04,
    ST_REF_WAIT = 6'h08,
    ST_REF      = 6'h10,
    ST_REF_EXT  = 6'h20
  } rha_state_e;

  // Pin inputs in one bundle; bit order matches the PIN_ positions.
  typedef struct packed {
    logic timer2_out;
    logic timer0_out;
    logic bus_clock;
    logic channel_ready;
    logic hold_ack;
    logic timer1_out;
    logic dma_hold_req;
    logic dma_clock;
  } rha_pins_s;

  // Refresh strobe and address drive towards the system bus.
  typedef struct packed {
    logic              refresh_n_o;
    logic              refresh_n_oe;
    logic [ADDR_W-1:0] sys_addr_low_o;
    logic              sys_addr_low_oe;
  } rha_bus_s;

endpackage

// *** src/rha_arbiter.sv ***
// Hold request arbiter and refresh generator of the peripheral controller.
`timescale 1ns/10ps

// Behaviour
// - Hold requests come from the DMA controller and from each low to high step of timer 1.
// - The CPU hold request is high while the DMA or the refresh source is requesting.
// - The DMA request is sampled on DMA clock rises and the timer request on its falls.
// - A winning DMA request raises hold and waits for hold acknowledge before granting.
// - When DMA drops, a pending refresh follows directly, otherwise hold falls.
// - A winning refresh raises hold and drives the active-low refresh strobe low.
// - The strobe stays low for four bus clock rises and hold falls on the fourth.
// - A DMA request pending on the fourth rise stretches the refresh to the next bus clock rise, then DMA gets the bus.
// - An 8-bit refresh address counter supplies system address bits 0 to 7 during refresh.
// - The refresh address is driven only while the refresh strobe is low.
// - A refresh-detect bit reads back as bit 4 of the system control port.
// - All three timer counters are clocked from a 1.25 MHz source, 10 MHz divided by 8.
// - Timer 0 drives interrupt request 0, timer 1 starts refreshes, timer 2 drives the speaker.
// - Withheld channel ready lengthens the refresh strobe by wait states.
module rha_arbiter (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       clk_en,
  input  wire rha_pkg::rha_pins_s         pins,
  output rha_pkg::rha_bus_s               bus,
  output logic                            hold_req,
  output logic                            dma_grant,
  output logic [rha_pkg::PORT_W-1:0]      system_control_port,
  output logic                            timer_clock,
  output logic                            irq0_req,
  output logic                            speaker_out
);

  logic [rha_pkg::SYNC_W-1:0] sync1_q;
  logic [rha_pkg::SYNC_W-1:0] sync2_q;
  logic [rha_pkg::SYNC_W-1:0] pins_v;

  assign pins_v = pins;

  // Two flip-flops for every pin that arrives from outside this clock.
  // Pin clock edges are found on the synchronised copies. The DMA clock and
  // the bus clock must therefore run well below half of clk, or edges merge.
  for (genvar i = 0; i < rha_pkg::SYNC_W; i++) begin : g_sync
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        sync1_q[i] <= 1'b0;
        sync2_q[i] <= 1'b0;
      end else if (clk_en) begin
        sync1_q[i] <= pins_v[i];
        sync2_q[i] <= sync1_q[i];
      end
    end
  end

  logic dma_clk_s;
  logic bus_clk_s;
  logic ack_s;
  logic rdy_s;
  assign dma_clk_s = sync2_q[rha_pkg::PIN_DMA_CLOCK];
  assign bus_clk_s = sync2_q[rha_pkg::PIN_BUS_CLOCK];
  assign ack_s     = sync2_q[rha_pkg::PIN_HOLD_ACK];
  assign rdy_s     = sync2_q[rha_pkg::PIN_CH_READY];

  // Request sampling group.
  logic dma_clk_prev_q;
  logic dma_clk_prev_d;
  logic bus_clk_prev_q;
  logic bus_clk_prev_d;
  logic dma_req_q;
  logic dma_req_d;
  logic t1_q;
  logic t1_d;
  logic ref_pend_q;
  logic ref_pend_d;
  logic dma_rise;
  logic dma_fall;
  logic bus_rise;
  logic ref_take;

  always_comb begin
    dma_clk_prev_d = dma_clk_s;
    bus_clk_prev_d = bus_clk_s;
    dma_rise       = dma_clk_s & ~dma_clk_prev_q;
    dma_fall       = ~dma_clk_s & dma_clk_prev_q;
    bus_rise       = bus_clk_s & ~bus_clk_prev_q;
    dma_req_d      = dma_req_q;
    t1_d           = t1_q;
    ref_pend_d     = ref_pend_q & ~ref_take;
    if (dma_rise) begin
      dma_req_d = sync2_q[rha_pkg::PIN_DMA_HOLD];
    end
    if (dma_fall) begin
      t1_d = sync2_q[rha_pkg::PIN_TIMER1];
      // A new timer step is kept even when the pending flag is taken now.
      if (sync2_q[rha_pkg::PIN_TIMER1] && !t1_q) begin
        ref_pend_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_clk_prev_q <= 1'b0;
      bus_clk_prev_q <= 1'b0;
      dma_req_q      <= 1'b0;
      t1_q           <= 1'b0;
      ref_pend_q     <= 1'b0;
    end else if (clk_en) begin
      dma_clk_prev_q <= dma_clk_prev_d;
      bus_clk_prev_q <= bus_clk_prev_d;
      dma_req_q      <= dma_req_d;
      t1_q           <= t1_d;
      ref_pend_q     <= ref_pend_d;
    end
  end

  // Arbitration and refresh group.
  rha_pkg::rha_state_e              st_q;
  rha_pkg::rha_state_e              st_d;
  logic [rha_pkg::REF_CNT_W-1:0]    cnt_q;
  logic [rha_pkg::REF_CNT_W-1:0]    cnt_d;
  logic [rha_pkg::ADDR_W-1:0]       addr_q;
  logic [rha_pkg::ADDR_W-1:0]       addr_d;
  logic                             det_q;
  logic                             det_d;
  logic                             hold_q;
  logic                             hold_d;
  logic                             strobe_d;
  logic                             grant_q;
  logic                             grant_d;
  logic                             ref_done;

  always_comb begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    addr_d   = addr_q;
    det_d    = det_q;
    ref_take = 1'b0;
    ref_done = 1'b0;
    case (st_q)
      rha_pkg::ST_IDLE: begin
        if (dma_req_q) begin
          st_d = rha_pkg::ST_DMA_WAIT;
        end else if (ref_pend_q) begin
          st_d     = rha_pkg::ST_REF_WAIT;
          ref_take = 1'b1;
        end
      end
      rha_pkg::ST_DMA_WAIT: begin
        if (ack_s) begin
          st_d = rha_pkg::ST_DMA;
        end
      end
      rha_pkg::ST_DMA: begin
        if (!dma_req_q) begin
          if (ref_pend_q) begin
            st_d     = rha_pkg::ST_REF;
            cnt_d    = rha_pkg::REF_CNT_RST;
            ref_take = 1'b1;
          end else begin
            st_d = rha_pkg::ST_IDLE;
          end
        end
      end
      rha_pkg::ST_REF_WAIT: begin
        if (ack_s) begin
          st_d  = rha_pkg::ST_REF;
          cnt_d = rha_pkg::REF_CNT_RST;
        end
      end
      rha_pkg::ST_REF: begin
        // Edges with channel ready withheld are wait states and do not count.
        if (bus_rise && rdy_s) begin
          if (cnt_q == rha_pkg::REF_LAST) begin
            if (dma_req_q) begin
              st_d = rha_pkg::ST_REF_EXT;
            end else begin
              st_d     = rha_pkg::ST_IDLE;
              ref_done = 1'b1;
            end
          end else begin
            cnt_d = cnt_q + 3'h1;
          end
        end
      end
      rha_pkg::ST_REF_EXT: begin
        if (bus_rise) begin
          st_d     = rha_pkg::ST_DMA;
          ref_done = 1'b1;
        end
      end
      default: begin
        st_d = rha_pkg::ST_IDLE;
      end
    endcase
    if (ref_done) begin
      addr_d = addr_q + rha_pkg::ADDR_STEP;
      det_d  = ~det_q;
    end
    hold_d   = (st_d != rha_pkg::ST_IDLE);
    strobe_d = (st_d == rha_pkg::ST_REF) || (st_d == rha_pkg::ST_REF_EXT);
    grant_d  = (st_d == rha_pkg::ST_DMA);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q     <= rha_pkg::ST_IDLE;
      cnt_q    <= rha_pkg::REF_CNT_RST;
      addr_q   <= rha_pkg::ADDR_RST;
      det_q    <= 1'b0;
      hold_q   <= 1'b0;
      grant_q  <= 1'b0;
    end else if (clk_en) begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      addr_q   <= addr_d;
      det_q    <= det_d;
      hold_q   <= hold_d;
      grant_q  <= grant_d;
    end
  end

  // Timer source and timer output wiring group.
  logic [rha_pkg::TDIV_W-1:0] tdiv_q;
  logic [rha_pkg::TDIV_W-1:0] tdiv_d;
  logic                       tick_q;
  logic                       tick_d;
  logic                       irq0_q;
  logic                       irq0_d;
  logic                       spk_q;
  logic                       spk_d;

  always_comb begin
    tick_d = (tdiv_q == rha_pkg::TDIV_LAST);
    tdiv_d = tick_d ? '0 : tdiv_q + 4'h1;
    irq0_d = sync2_q[rha_pkg::PIN_TIMER0];
    spk_d  = sync2_q[rha_pkg::PIN_TIMER2];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tdiv_q <= '0;
      tick_q <= 1'b0;
      irq0_q <= 1'b0;
      spk_q  <= 1'b0;
    end else if (clk_en) begin
      tdiv_q <= tdiv_d;
      tick_q <= tick_d;
      irq0_q <= irq0_d;
      spk_q  <= spk_d;
    end
  end

  // Output register group.
  // The strobe, its enable and the address are registered from the next
  // state values, so they change on the same edge as the state itself.
  // The strobe leaves reset high, so no false refresh shows at power up.
  rha_pkg::rha_bus_s          bus_q;
  rha_pkg::rha_bus_s          bus_d;
  logic [rha_pkg::PORT_W-1:0] port_q;
  logic [rha_pkg::PORT_W-1:0] port_d;

  always_comb begin
    bus_d.refresh_n_o             = ~strobe_d;
    bus_d.refresh_n_oe            = strobe_d;
    bus_d.sys_addr_low_o          = addr_d;
    bus_d.sys_addr_low_oe         = strobe_d;
    port_d                        = '0;
    port_d[rha_pkg::PORT_REF_BIT] = det_d;
    port_d[rha_pkg::PORT_SPK_BIT] = spk_d;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_q.refresh_n_o     <= 1'b1;
      bus_q.refresh_n_oe    <= 1'b0;
      bus_q.sys_addr_low_o  <= rha_pkg::ADDR_RST;
      bus_q.sys_addr_low_oe <= 1'b0;
      port_q                <= '0;
    end else if (clk_en) begin
      bus_q  <= bus_d;
      port_q <= port_d;
    end
  end

  // Every port below is a plain copy of one register.
  assign hold_req             = hold_q;
  assign dma_grant            = grant_q;
  assign timer_clock          = tick_q;
  assign irq0_req             = irq0_q;
  assign speaker_out          = spk_q;
  assign system_control_port  = port_q;
  assign bus                  = bus_q;

endmodule // rha_arbiter

// *** testbench/rha_cpu_model.sv ***
// Host CPU model answering hold requests with hold acknowledge.
`timescale 1ns/10ps
module rha_cpu_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic hold_req,
  input  wire logic slow,
  output logic      hold_ack
);
  int n;
  always @(negedge clk or negedge rst_n) begin
    if (!rst_n || !hold_req) begin
      n <= 0;
      hold_ack <= 1'h0;
    end else begin
      n <= n + 1;
      hold_ack <= n >= (slow ? 12 : 2);
    end
  end
endmodule // rha_cpu_model

// *** testbench/rha_arbiter_asserts.sv ***
// Port checks of the refresh and hold arbiter.
`timescale 1ns/10ps
module rha_arbiter_asserts (
  input wire logic                       clk,
  input wire logic                       rst_n,
  input wire rha_pkg::rha_pins_s         pins,
  input wire rha_pkg::rha_bus_s          bus,
  input wire logic                       hold_req,
  input wire logic                       dma_grant,
  input wire logic [rha_pkg::PORT_W-1:0] system_control_port
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_addr_oe;
    !bus.refresh_n_o == bus.sys_addr_low_oe;
  endproperty
  a_addr_oe: assert property (p_addr_oe) else $error("address drive off strobe");
  property p_strobe;
    !bus.refresh_n_o |-> hold_req && bus.refresh_n_oe;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe without hold");
  property p_grant;
    dma_grant |-> hold_req;
  endproperty
  a_grant: assert property (p_grant) else $error("grant without hold");
  property p_grant_ack;
    $rose(dma_grant) |-> $past(pins.hold_ack, 2);
  endproperty
  a_grant_ack: assert property (p_grant_ack) else $error("grant before ack");
  property p_len;
    $fell(bus.refresh_n_o) |-> !bus.refresh_n_o [*8];
  endproperty
  a_len: assert property (p_len) else $error("strobe too short");
  property p_end;
    $rose(bus.refresh_n_o) |-> hold_req == dma_grant;
  endproperty
  a_end: assert property (p_end) else $error("hold wrong at strobe end");
  property p_step;
    $rose(bus.refresh_n_o) |-> bus.sys_addr_low_o == $past(bus.sys_addr_low_o) + 8'h01;
  endproperty
  a_step: assert property (p_step) else $error("address not stepped");
  property p_det;
    $rose(bus.refresh_n_o) |-> system_control_port[rha_pkg::PORT_REF_BIT] !=
      $past(system_control_port[rha_pkg::PORT_REF_BIT]);
  endproperty
  a_det: assert property (p_det) else $error("detect bit not toggled");
endmodule // rha_arbiter_asserts

bind rha_arbiter rha_arbiter_asserts rha_arbiter_asserts_i (
  .clk, .rst_n, .pins, .bus, .hold_req, .dma_grant, .system_control_port
);

// *** testbench/test_refresh_hold_arbiter.sv ***
// Bench of the refresh and hold arbiter.
`timescale 1ns/10ps
module test_refresh_hold_arbiter;
  logic                       clk = 1'h0, rst_n = 1'h0, dc = 1'h0, dr = 1'h0, t1 = 1'h0;
  logic                       bc = 1'h0, run = 1'h0, t0 = 1'h0, t2 = 1'h0, slow = 1'h0;
  logic                       rdy = 1'h1, ack, hold_req, dma_grant, timer_clock, irq0_req, spk;
  logic [2:0]                 ph = 3'h0;
  logic [7:0]                 ea = 8'h00;
  logic [rha_pkg::PORT_W-1:0] scp;
  rha_pkg::rha_bus_s          bus;
  int                         n_errors = 0, checks = 0;
  initial forever #50 clk = ~clk;
  initial forever #400 dc = ~dc;
  // The bus clock runs only while a refresh counts its rises, so its phase is known.
  always @(negedge clk) begin
    if (run) begin
      ph <= ph + 3'h1;
      bc <= ph[2];
    end
  end
  rha_arbiter rha_arbiter_i (
    .clk, .rst_n, .clk_en(1'h1), .pins({t2, t0, bc, rdy, ack, t1, dr, dc}), .bus, .hold_req,
    .dma_grant, .system_control_port(scp), .timer_clock, .irq0_req, .speaker_out(spk)
  );
  rha_cpu_model rha_cpu_model_i (.clk, .rst_n, .hold_req, .slow, .hold_ack(ack));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_ref(output logic h);
    h = 1'h1;
    for (int i = 0; i < 200 && bus.refresh_n_o !== 1'h0; i++) begin
      @(negedge clk);
      h &= hold_req;
    end
    chk("strobe", 8'h00, 8'(bus.refresh_n_o));
  endtask
  task automatic wait_hold;
    for (int i = 0; i < 100 && hold_req !== 1'h0; i++) @(negedge clk);
    chk("hold", 8'h00, 8'(hold_req));
  endtask
  task automatic end_ref(input int stall, input logic ext);
    int r;
    logic p, d;
    r = 0;
    p = bc;
    d = scp[4];
    chk("addr", ea, bus.sys_addr_low_o);
    rdy = stall == 0;
    run <= 1'h1;
    while (bus.refresh_n_o === 1'h0 && r < 12) begin
      @(negedge clk);
      r += bc && !p;
      p = bc;
      rdy = r >= stall;
      dr = ext && r >= 2;
    end
    run <= 1'h0;
    ea++;
    chk("rises", 8'(4 + stall + ext), 8'(r));
    chk("grant", 8'(ext), 8'(dma_grant));
    chk("addr", ea, bus.sys_addr_low_o);
    chk("detect", 8'(!d), 8'(scp[4]));
  endtask
  task automatic t_ref(input int stall, input logic ext);
    logic h;
    t1 = 1'h1;
    wait_ref(h);
    t1 = 1'h0;
    end_ref(stall, ext);
    if (ext) begin
      @(negedge clk);
      dr = 1'h0;
      wait_hold;
    end
  endtask
  task automatic t_dma(input logic pend);
    logic h;
    dr = 1'h1;
    for (int i = 0; i < 100 && dma_grant !== 1'h1; i++) @(negedge clk);
    chk("grant", 8'h01, 8'(dma_grant));
    t1 = pend;
    repeat (16) @(negedge clk);
    t1 = 1'h0;
    dr = 1'h0;
    if (pend) begin
      wait_ref(h);
      chk("hold_kept", 8'h01, 8'(h));
      end_ref(0, 1'h0);
    end else begin
      wait_hold;
    end
  endtask
  task automatic t_tmr;
    int n;
    n = 0;
    t0 = 1'h1;
    t2 = 1'h1;
    repeat (80) begin
      @(negedge clk);
      n += timer_clock;
    end
    chk("tclk", 8'(80 / rha_pkg::TIMER_DIV), 8'(n));
    chk("irq0", 8'h01, 8'(irq0_req));
    chk("spk", 8'h01, 8'(spk));
    chk("port_spk", 8'h01, 8'(scp[5]));
  endtask
  task automatic end_sim;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #6_000_000;
    n_errors++;
    end_sim;
  end
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'h1;
    @(negedge clk);
    chk("hold", 8'h00, 8'(hold_req));
    chk("port", 8'h00, scp);
    repeat (257) t_ref(0, 1'h0);
    slow = 1'h1;
    t_ref(2, 1'h0);
    slow = 1'h0;
    t_ref(0, 1'h1);
    t_dma(1'h0);
    t_dma(1'h1);
    t_tmr;
    end_sim;
  end
endmodule // test_refresh_hold_arbiter
